// ---- hdl/lddc_pkg.sv ----
// Purpose: shared constants and types of the laser driver setting control
// Assumes: 200 MHz system clock
// Notes:   table selects address the nonvolatile write port
package lddc_pkg;
  localparam int unsigned DAC_W         = 8;
  localparam int unsigned DUTY_W        = 5;
  localparam int unsigned TEMP_W        = 7;
  localparam int unsigned BAND_W        = 5;
  // temperature code is in 1.5 C steps, four codes make one 6 C band
  localparam int unsigned BAND_SHIFT    = 2;
  localparam int unsigned TEMP_ENTRIES  = 128;
  localparam int unsigned BAND_ENTRIES  = 32;
  localparam int unsigned CLK_FREQ_HZ   = 200_000_000;
  localparam int unsigned DETECT_PERIOD_MS = 128;
  localparam int unsigned DETECT_CYC    = DETECT_PERIOD_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned TIMER_W       = 25;

  localparam logic [1:0] HOST_MODE_SELF = 2'h0;
  localparam logic [1:0] HOST_MODE_ADJ  = 2'h1;
  localparam logic [1:0] HOST_MODE_NVM  = 2'h2;

  localparam logic [1:0] TAB_MOD  = 2'h0;
  localparam logic [1:0] TAB_BIAS = 2'h1;
  localparam logic [1:0] TAB_DUTY = 2'h2;

  localparam logic [DAC_W-1:0]  DAC_RST  = 8'h00;
  localparam logic [DUTY_W-1:0] DUTY_RST = 5'h00;

  typedef enum logic [2:0] {
    MODE_SELF = 3'b001,
    MODE_ADJ  = 3'b010,
    MODE_NVM  = 3'b100
  } lddc_mode_e;

  typedef enum logic [3:0] {
    SEQ_WAIT   = 4'b0001,
    SEQ_DETECT = 4'b0010,
    SEQ_READ   = 4'b0100,
    SEQ_DRIVE  = 4'b1000
  } lddc_seq_e;
endpackage

// ---- hdl/lddc_seq_if.sv ----
// Purpose: strobes between the core and the self-running sequencer
// Assumes: single clock domain
// Notes:   run gates the sequencer, strobes are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface lddc_seq_if;
  logic run;
  logic temp_load;
  logic table_read;
  logic apply;
  modport seq  (input run, output temp_load, output table_read, output apply);
  modport core (output run, input temp_load, input table_read, input apply);
endinterface
`default_nettype wire

// ---- hdl/lddc_seq.sv ----
// Purpose: oscillator-timed detect, read and drive sequence
// Assumes: run is high only in self-running mode
// Notes:   first detection follows reset without waiting a period
`timescale 1ns/1ps
`default_nettype none
module lddc_seq
  import lddc_pkg::*;
#(
  parameter int unsigned PERIOD_CYCLES = lddc_pkg::DETECT_CYC
)(
  // clock and reset
  input  wire logic  sys_clk_i,
  input  wire logic  reset_n_i,
  // strobes to the core
  lddc_seq_if.seq    sq
);
  import lddc_pkg::*;

  localparam logic [TIMER_W-1:0] PERIOD_LAST = TIMER_W'(PERIOD_CYCLES - 1);

  lddc_seq_e          state_q, state_d;
  logic [TIMER_W-1:0] timer_q, timer_d;
  logic               due;

  assign due = (timer_q == '0);

  always_comb
  begin
    state_d = state_q;
    timer_d = timer_q;
    if (timer_q != '0)
    begin
      timer_d = timer_q - 1'b1;
    end
    unique case (state_q)
      SEQ_WAIT:
      begin
        if (sq.run && due)
        begin
          state_d = SEQ_DETECT;
          timer_d = PERIOD_LAST;
        end
      end
      SEQ_DETECT: state_d = SEQ_READ;
      SEQ_READ:   state_d = SEQ_DRIVE;
      SEQ_DRIVE:  state_d = SEQ_WAIT;
      default:    state_d = SEQ_WAIT;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      state_q <= SEQ_WAIT;
      timer_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      timer_q <= timer_d;
    end
  end

  // sequence steps: detect, read table, drive currents
  assign sq.temp_load  = (state_q == SEQ_DETECT);
  assign sq.table_read = (state_q == SEQ_READ);
  assign sq.apply      = (state_q == SEQ_DRIVE) && sq.run;
endmodule
`default_nettype wire

// ---- hdl/lddc_top.sv ----
// Purpose: setting control of a laser diode driver
// Assumes: host mode and settings come from serial logic on sys_clk_i
// Notes:   pins pass two flip-flops before use
`timescale 1ns/1ps
`default_nettype none
module lddc_top
  import lddc_pkg::*;
#(
  parameter int unsigned PERIOD_CYCLES = lddc_pkg::DETECT_CYC
)(
  // clock and reset
  input  wire logic                          sys_clk_i,
  input  wire logic                          reset_n_i,
  // host mode and adjustment settings
  input  wire logic [1:0]                    host_mode_i,
  input  wire logic [lddc_pkg::DAC_W-1:0]    adj_mod_code_i,
  input  wire logic [lddc_pkg::DAC_W-1:0]    adj_bias_code_i,
  input  wire logic [lddc_pkg::DUTY_W-1:0]   adj_duty_code_i,
  input  wire logic                          mod_dac_gain_sel_i,
  input  wire logic                          bias_dac_gain_sel_i,
  // nonvolatile table write port
  input  wire logic                          nvm_wr_i,
  input  wire logic [1:0]                    nvm_tab_i,
  input  wire logic [lddc_pkg::TEMP_W-1:0]   nvm_addr_i,
  input  wire logic [lddc_pkg::DAC_W-1:0]    nvm_wdata_i,
  // temperature converter
  input  wire logic [lddc_pkg::TEMP_W-1:0]   temp_code_i,
  // pins
  input  wire logic                          data_in_pos_i,
  input  wire logic                          retime_clk_pos_i,
  input  wire logic                          data_latch_sel_i,
  input  wire logic                          tx_disable_a_i,
  input  wire logic                          tx_disable_b_i,
  // driver controls
  output logic                               data_drive_o,
  output logic [lddc_pkg::DAC_W-1:0]         mod_current_dac_o,
  output logic [lddc_pkg::DAC_W-1:0]         bias_current_dac_o,
  output logic                               mod_gain_full_o,
  output logic                               bias_gain_full_o,
  output logic                               dac_shutdown_o,
  output logic [lddc_pkg::DUTY_W-1:0]        duty_code_o,
  output logic [2:0]                         mode_o,
  output logic [lddc_pkg::TEMP_W-1:0]        temp_code_o
);
  import lddc_pkg::*;

  localparam int unsigned NSYNC = 5;

  lddc_seq_if sq ();

  lddc_seq #(
    .PERIOD_CYCLES (PERIOD_CYCLES)
  ) u_seq (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .sq        (sq)
  );

  // pin synchronisers
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] pin_s1_q;
  logic [NSYNC-1:0] pin_s2_q;
  logic             clk_prev_q;

  // select strap is a pin as well, so it is synchronised with the rest
  assign pin_raw = {data_latch_sel_i, tx_disable_b_i, tx_disable_a_i,
                    retime_clk_pos_i, data_in_pos_i};

  for (genvar g = 0; g < NSYNC; g++)
  begin : g_sync
    always_ff @(posedge sys_clk_i)
    begin
      if (!reset_n_i)
      begin
        pin_s1_q[g] <= 1'b0;
        pin_s2_q[g] <= 1'b0;
      end
      else
      begin
        pin_s1_q[g] <= pin_raw[g];
        pin_s2_q[g] <= pin_s1_q[g];
      end
    end
  end

  // operating mode
  lddc_mode_e mode_q, mode_d;

  always_comb
  begin
    unique case (host_mode_i)
      HOST_MODE_ADJ: mode_d = MODE_ADJ;
      HOST_MODE_NVM: mode_d = MODE_NVM;
      default:       mode_d = MODE_SELF;
    endcase
  end

  assign sq.run = (mode_q == MODE_SELF);

  // nonvolatile tables
  logic [DAC_W-1:0]  mod_tab  [TEMP_ENTRIES];
  logic [DAC_W-1:0]  bias_tab [TEMP_ENTRIES];
  logic [DUTY_W-1:0] duty_temp_table [BAND_ENTRIES];
  logic              nvm_we;
  logic [BAND_W-1:0] nvm_band;

  assign nvm_we   = nvm_wr_i && (mode_q == MODE_NVM);
  assign nvm_band = nvm_addr_i[TEMP_W-1:BAND_SHIFT];

  always_ff @(posedge sys_clk_i)
  begin
    if (nvm_we && nvm_tab_i == TAB_MOD)
    begin
      mod_tab[nvm_addr_i] <= nvm_wdata_i;
    end
    if (nvm_we && nvm_tab_i == TAB_BIAS)
    begin
      bias_tab[nvm_addr_i] <= nvm_wdata_i;
    end
    if (nvm_we && nvm_tab_i == TAB_DUTY)
    begin
      duty_temp_table[nvm_band] <= nvm_wdata_i[DUTY_W-1:0];
    end
  end

  // temperature and table lookup
  logic [TEMP_W-1:0] temp_q, temp_d;
  logic [DAC_W-1:0]  mod_rd_q, mod_rd_d;
  logic [DAC_W-1:0]  bias_rd_q, bias_rd_d;
  logic [DUTY_W-1:0] duty_rd_q, duty_rd_d;

  always_comb
  begin
    temp_d    = temp_q;
    mod_rd_d  = mod_rd_q;
    bias_rd_d = bias_rd_q;
    duty_rd_d = duty_rd_q;
    if (sq.temp_load)
    begin
      temp_d = temp_code_i;
    end
    if (sq.table_read)
    begin
      mod_rd_d  = mod_tab[temp_q];
      bias_rd_d = bias_tab[temp_q];
      duty_rd_d = duty_temp_table[temp_q[TEMP_W-1:BAND_SHIFT]];
    end
  end

  // applied settings
  logic [DAC_W-1:0]  mod_q, mod_d;
  logic [DAC_W-1:0]  bias_q, bias_d;
  logic [DUTY_W-1:0] duty_q, duty_d;
  logic              mgain_q, mgain_d;
  logic              bgain_q, bgain_d;
  logic              shut_q, shut_d;
  logic [DAC_W-1:0]  mod_out_q, mod_out_d;
  logic [DAC_W-1:0]  bias_out_q, bias_out_d;

  always_comb
  begin
    mod_d   = mod_q;
    bias_d  = bias_q;
    duty_d  = duty_q;
    mgain_d = mod_dac_gain_sel_i;
    bgain_d = bias_dac_gain_sel_i;
    shut_d  = pin_s2_q[2] | pin_s2_q[3];
    if (mode_q == MODE_ADJ)
    begin
      mod_d  = adj_mod_code_i;
      bias_d = adj_bias_code_i;
      duty_d = adj_duty_code_i;
    end
    else if (sq.apply)
    begin
      mod_d  = mod_rd_q;
      bias_d = bias_rd_q;
      duty_d = duty_rd_q;
    end
    // gated codes registered so the outputs come from flip-flops
    mod_out_d  = shut_d ? DAC_RST : mod_d;
    bias_out_d = shut_d ? DAC_RST : bias_d;
  end

  // data path
  logic data_q, data_d;
  logic clk_rise;

  assign clk_rise = pin_s2_q[1] && !clk_prev_q;

  always_comb
  begin
    if (!pin_s2_q[4])
    begin
      data_d = pin_s2_q[0];
    end
    else if (clk_rise)
    begin
      data_d = pin_s2_q[0];
    end
    else
    begin
      data_d = data_q;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      mode_q     <= MODE_SELF;
      temp_q     <= '0;
      mod_rd_q   <= DAC_RST;
      bias_rd_q  <= DAC_RST;
      duty_rd_q  <= DUTY_RST;
      mod_q      <= DAC_RST;
      bias_q     <= DAC_RST;
      duty_q     <= DUTY_RST;
      mgain_q    <= 1'b1;
      bgain_q    <= 1'b1;
      shut_q     <= 1'b1;
      mod_out_q  <= DAC_RST;
      bias_out_q <= DAC_RST;
      data_q     <= 1'b0;
      clk_prev_q <= 1'b0;
    end
    else
    begin
      mode_q     <= mode_d;
      temp_q     <= temp_d;
      mod_rd_q   <= mod_rd_d;
      bias_rd_q  <= bias_rd_d;
      duty_rd_q  <= duty_rd_d;
      mod_q      <= mod_d;
      bias_q     <= bias_d;
      duty_q     <= duty_d;
      mgain_q    <= mgain_d;
      bgain_q    <= bgain_d;
      shut_q     <= shut_d;
      mod_out_q  <= mod_out_d;
      bias_out_q <= bias_out_d;
      data_q     <= data_d;
      clk_prev_q <= pin_s2_q[1];
    end
  end

  // outputs, current DAC codes forced to zero during shutdown, duty code not gated
  assign data_drive_o       = data_q;
  assign mod_current_dac_o  = mod_out_q;
  assign bias_current_dac_o = bias_out_q;
  assign mod_gain_full_o    = mgain_q;
  assign bias_gain_full_o   = bgain_q;
  assign dac_shutdown_o     = shut_q;
  assign duty_code_o        = duty_q;
  assign mode_o             = mode_q;
  assign temp_code_o        = temp_q;
endmodule
`default_nettype wire

// ---- testbench/lddc_chk.sv ----
// Purpose: port checks of the setting control
// Assumes: synchronous active-low reset
// Notes:   latencies as handed over by design
`timescale 1ns/1ps
`default_nettype none
module lddc_chk
  import lddc_pkg::*;
(
  input wire logic                        sys_clk_i,
  input wire logic                        reset_n_i,
  input wire logic [1:0]                  host_mode_i,
  input wire logic [lddc_pkg::DAC_W-1:0]  adj_mod_code_i,
  input wire logic [lddc_pkg::DAC_W-1:0]  adj_bias_code_i,
  input wire logic [lddc_pkg::DUTY_W-1:0] adj_duty_code_i,
  input wire logic                        mod_dac_gain_sel_i,
  input wire logic                        bias_dac_gain_sel_i,
  input wire logic                        data_in_pos_i,
  input wire logic                        data_latch_sel_i,
  input wire logic                        tx_disable_a_i,
  input wire logic                        tx_disable_b_i,
  input wire logic                        data_drive_o,
  input wire logic [lddc_pkg::DAC_W-1:0]  mod_current_dac_o,
  input wire logic [lddc_pkg::DAC_W-1:0]  bias_current_dac_o,
  input wire logic                        mod_gain_full_o,
  input wire logic                        bias_gain_full_o,
  input wire logic                        dac_shutdown_o,
  input wire logic [lddc_pkg::DUTY_W-1:0] duty_code_o,
  input wire logic [2:0]                  mode_o,
  input wire logic [lddc_pkg::TEMP_W-1:0] temp_code_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_mode_self: assert property (host_mode_i inside {2'h0, 2'h3} |=> mode_o == 3'b001)
    else $error("mode not self-running");
  a_mode_adj: assert property (host_mode_i == 2'h1 |=> mode_o == 3'b010)
    else $error("mode not adjustment");
  a_mode_store: assert property (host_mode_i == 2'h2 |=> mode_o == 3'b100)
    else $error("mode not storage");
  a_adj_apply: assert property (mode_o == 3'b010 |=> dac_shutdown_o ||
    (mod_current_dac_o == $past(adj_mod_code_i) && bias_current_dac_o == $past(adj_bias_code_i)
    && duty_code_o == $past(adj_duty_code_i))) else $error("adjust values not applied");
  a_shut_zero: assert property (dac_shutdown_o |-> mod_current_dac_o == 8'h00 &&
    bias_current_dac_o == 8'h00) else $error("codes live in shutdown");
  a_dis_or: assert property (tx_disable_a_i || tx_disable_b_i |-> ##3 dac_shutdown_o)
    else $error("disable not taken");
  a_dis_release: assert property (!(tx_disable_a_i || tx_disable_b_i) [*3]
    |=> !dac_shutdown_o) else $error("shutdown not released");
  a_gain_copy: assert property ($past(reset_n_i) |-> mod_gain_full_o ==
    $past(mod_dac_gain_sel_i) && bias_gain_full_o == $past(bias_dac_gain_sel_i))
    else $error("gain select not followed");
  a_data_direct: assert property (!data_latch_sel_i [*4] |->
    data_drive_o == $past(data_in_pos_i, 3)) else $error("direct data wrong");
  a_temp_frozen: assert property ($changed(temp_code_o) |->
    $past(mode_o) == 3'b001 || $past(mode_o, 2) == 3'b001) else $error("temp outside self");
  c_adj_self: cover property (mode_o == 3'b010 ##1 mode_o == 3'b001);
  c_shut_cycle: cover property (dac_shutdown_o ##1 !dac_shutdown_o);
  c_temp_new: cover property ($changed(temp_code_o));
endmodule
bind lddc_top lddc_chk u_lddc_chk (.sys_clk_i, .reset_n_i, .host_mode_i, .adj_mod_code_i,
  .adj_bias_code_i, .adj_duty_code_i, .mod_dac_gain_sel_i, .bias_dac_gain_sel_i,
  .data_in_pos_i, .data_latch_sel_i, .tx_disable_a_i, .tx_disable_b_i, .data_drive_o,
  .mod_current_dac_o, .bias_current_dac_o, .mod_gain_full_o, .bias_gain_full_o,
  .dac_shutdown_o, .duty_code_o, .mode_o, .temp_code_o);
`default_nettype wire

// ---- testbench/lddc_host_model.sv ----
// Purpose: host side of mode, adjust and table ports
// Assumes: driven on falling clock edges
// Notes:   data lines invert after a write strobe
`timescale 1ns/1ps
`default_nettype none
module lddc_host_model
  import lddc_pkg::*;
(
  input  wire logic                   sys_clk_i,
  output logic [1:0]                  host_mode_o,
  output logic [lddc_pkg::DAC_W-1:0]  mod_o,
  output logic [lddc_pkg::DAC_W-1:0]  bias_o,
  output logic [lddc_pkg::DUTY_W-1:0] duty_o,
  output logic                        gm_o,
  output logic                        gb_o,
  output logic                        wr_o,
  output logic [1:0]                  tab_o,
  output logic [lddc_pkg::TEMP_W-1:0] addr_o,
  output logic [lddc_pkg::DAC_W-1:0]  wdata_o
);
  initial
  begin
    {host_mode_o, mod_o, bias_o, duty_o, wr_o, tab_o, addr_o, wdata_o} = '0;
    {gm_o, gb_o} = 2'h3;
  end
  task automatic set_mode(input logic [1:0] m);
    @(negedge sys_clk_i);
    host_mode_o = m;
  endtask
  task automatic adjust(input logic [22:0] r);
    @(negedge sys_clk_i);
    {mod_o, bias_o, duty_o, gm_o, gb_o} = r[22:0];
  endtask
  task automatic nvm_write(input logic [1:0] t, input logic [6:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    {wr_o, tab_o, addr_o, wdata_o} = {1'b1, t, a, d};
    @(negedge sys_clk_i);
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Purpose: self-checking bench of the setting control
// Assumes: short detection period of 20 cycles
// Notes:   bench drives pins, host model drives settings
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_top;
  import lddc_pkg::*;
  logic clk = 0, rst_n = 0, din = 0, rclk = 0, sel = 0, txa = 0, txb = 0;
  logic [6:0] temp = 7'h2A;
  logic [1:0] hm, tab;
  logic [7:0] hmod, hbias, wd, mod, bias;
  logic [4:0] hduty, duty;
  logic [6:0] addr, tco;
  logic       gm, gb, wr, dd, gmf, gbf, shut;
  logic [2:0] mode;
  logic [22:0] rows [4] = '{23'h0, 23'h7FFFFF, {8'h55, 8'hAA, 5'h10, 1'b0, 1'b1},
                            {8'h80, 8'h01, 5'h01, 1'b1, 1'b0}};
  int num_errors = 0, samples_checked = 0, cycles = 0;
  lddc_host_model u_lddc_host_model (.sys_clk_i(clk), .host_mode_o(hm), .mod_o(hmod),
    .bias_o(hbias), .duty_o(hduty), .gm_o(gm), .gb_o(gb), .wr_o(wr), .tab_o(tab),
    .addr_o(addr), .wdata_o(wd));
  lddc_top #(.PERIOD_CYCLES(20)) u_lddc_top (.sys_clk_i(clk), .reset_n_i(rst_n),
    .host_mode_i(hm), .adj_mod_code_i(hmod), .adj_bias_code_i(hbias), .adj_duty_code_i(hduty),
    .mod_dac_gain_sel_i(gm), .bias_dac_gain_sel_i(gb), .nvm_wr_i(wr), .nvm_tab_i(tab),
    .nvm_addr_i(addr), .nvm_wdata_i(wd), .temp_code_i(temp), .data_in_pos_i(din),
    .retime_clk_pos_i(rclk), .data_latch_sel_i(sel), .tx_disable_a_i(txa),
    .tx_disable_b_i(txb), .data_drive_o(dd), .mod_current_dac_o(mod),
    .bias_current_dac_o(bias), .mod_gain_full_o(gmf), .bias_gain_full_o(gbf),
    .dac_shutdown_o(shut), .duty_code_o(duty), .mode_o(mode), .temp_code_o(tco));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  task automatic tally_and_finish();
    if (num_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial
  begin
    wait_n(10);
    `CHK({mode, shut, mod, duty, gmf, dd, tco}, {3'b001, 1'b1, 8'h00, 5'h00, 1'b1, 1'b0, 7'h00})
    rst_n = 1;
    u_lddc_host_model.set_mode(2'h2);
    u_lddc_host_model.nvm_write(2'h0, 7'h2A, 8'h5C);
    u_lddc_host_model.nvm_write(2'h1, 7'h2A, 8'h3B);
    for (int i = 0; i < 32; i++)
      u_lddc_host_model.nvm_write(2'h2, 7'(i * 4), 8'hF3);
    u_lddc_host_model.set_mode(2'h1);
    foreach (rows[i])
    begin
      u_lddc_host_model.adjust(rows[i]);
      wait_n(3);
      `CHK({mode, mod, bias, duty, gmf, gbf}, {3'b010, rows[i]})
    end
    u_lddc_host_model.nvm_write(2'h0, 7'h2A, 8'hFF);
    temp = 7'h10;
    wait_n(30);
    `CHK({mod, duty, tco}, {8'h80, 5'h01, 7'h2A})
    temp = 7'h2A;
    u_lddc_host_model.set_mode(2'h3);
    wait_n(50);
    `CHK({mode, mod, bias, duty, tco}, {3'b001, 8'h5C, 8'h3B, 5'h13, 7'h2A})
    txa = 1;
    wait_n(4);
    `CHK({shut, mod, bias}, {1'b1, 16'h0})
    txa = 0;
    wait_n(4);
    `CHK({shut, mod}, {1'b0, 8'h5C})
    txb = 1;
    wait_n(4);
    `CHK({shut, bias}, {1'b1, 8'h00})
    txb = 0;
    din = 1;
    wait_n(4);
    `CHK(dd, 1'b1)
    sel = 1;
    rclk = 1;
    wait_n(6);
    din = 0;
    rclk = 0;
    wait_n(6);
    `CHK(dd, 1'b1)
    rclk = 1;
    wait_n(6);
    `CHK(dd, 1'b0)
    rst_n = 0;
    wait_n(3);
    `CHK({mode, shut}, {3'b001, 1'b1})
    rst_n = 1;
    wait_n(5);
    `CHK({shut, mode, mod}, {1'b0, 3'b001, 8'h5C})
    tally_and_finish();
  end
endmodule
`default_nettype wire
